/* hw/aodm_demux.sv */
// output demultiplexer, test pattern source and wishbone status port
//
// How it works
// - four 8-bit lanes carry successive samples
// - lanes load at quarter rate; data clock at quarter, eighth, sixteenth rate
// - lane latencies 10.5, 9.5, 8.5, 7.5 clocks
// - 8-bit feedback shift register, 255 states
// - pattern replaces converter data while selected
// - pattern follows fixed sequence, then repeats
// - saturate to all ones or zeros, flag set
// - codes pass as offset binary
// - sample taken on sample clock rising edge
// - lane data changes every four samples, on data clock rise in base mode
// - demux reset holds the phase at zero and freezes the lanes
// - reset output for downstream demux alignment
// - mode decode: base, double, quad
// - over-range flag aligned with lane data
// - reset output 7.5 clocks after release
//
// timing overview
// - every converter side pin passes two flops before use
// - the sample clock is found by edge detection on clk_i
// - clk_i must run well above twice the sample clock rate
// - a sample rise shifts one word into the history line
// - each history word is nine bits: range flag and code
// - history depth covers the oldest lane plus one
// - lane words leave at a sample fall, hence the half clock
// - lane d takes history slot 7, lane a slot 10
// - so a lane load always holds four consecutive samples
// - lanes load only when the two-bit phase reads zero
// - phase and data clock counter step at sample rises
//
// demux reset
// - demux reset is looked at on sample rises, and at falls to stop lane loads
// - while it stands, the phase is held at zero
// - lanes keep their last words, no load happens
// - the data clock counter keeps running throughout
// - at the release rise the phase is loaded to one
// - the data clock counter is loaded to nine there
// - a marker enters the history line at that rise
// - the marker reaches slot 7 seven rises later
// - at the fall after it, lanes load and data clock rises
// - reset out is high while the marker sits in slots 7..10
// - that gives a pulse of four sample clocks
// - downstream parts see it aligned to lane d data
//
// rate modes
// - lanes load every four samples in every mode
// - only the data clock period follows the mode
// - base: four samples, double: eight, quad: sixteen
// - the capture side latches on every data clock rise
// - mode pins are static; a change mid-run is not aligned
//
// pattern source
// - eight-bit register, steps once per sample rise
// - steps only while pattern select is high
// - holds its value otherwise, demux reset leaves it
// - system reset loads the seed value one
// - the last state steps back to the seed
// - pattern words never carry the range flag
//
// range handling
// - positive overflow wins when both overflow pins stand
// - saturated words carry the flag into the history
// - the lane flag is the or of the four loaded flags
//
// register port
// - classic wishbone, one wait state, ack for one cycle
// - status bits are sticky and cleared by a status read
// - an event in the clearing cycle stays set
// - interrupt is a flop of status and mask
// - unmapped offsets read as zero, writes need byte lane 0
// - the info word shows pins, phase and pattern register
`timescale 1ns/1ps
`default_nettype none

module aodm_demux (
  input wire logic clk_i, // 200 MHz system clock
  input wire logic srst_i, // synchronous reset, high
  // converter side pins, asynchronous
  input wire logic sample_clock_i, // true sample clock
  input wire logic [7:0] quant_code_i, // quantizer code
  input wire logic over_pos_i, // at or above +full scale
  input wire logic over_neg_i, // below -full scale
  input wire logic demux_reset_i, // demux reset in
  input wire logic double_rate_select_i, // rate select
  input wire logic quad_rate_select_i, // rate select
  input wire logic test_pattern_select_i, // pattern on
  // lane outputs
  output logic [7:0] lane_a_o, // oldest sample
  output logic [7:0] lane_b_o, // lane b
  output logic [7:0] lane_c_o, // lane c
  output logic [7:0] lane_d_o, // newest sample
  output logic over_range_flag_o, // any lane out of range
  output logic data_clock_out_o, // forwarded data clock
  output logic demux_reset_out_o, // aligned reset out
  // wishbone classic slave
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [3:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic irq_o // level interrupt
);

  typedef struct packed {
    logic [aodm_pkg::PIN_BITS-1:0] pin_s1;
    logic [aodm_pkg::PIN_BITS-1:0] pin_s2;
    logic [7:0] code_s1;
    logic [7:0] code_s2;
    logic [1:0] ovr_s1;
    logic [1:0] ovr_s2;
    logic sclk_prev;
    logic drst_prev;
    logic [aodm_pkg::HIST_DEPTH-1:0][8:0] hist;
    logic [aodm_pkg::HIST_DEPTH-1:0] mark;
    logic [1:0] phase;
    logic [3:0] dco_cnt;
    logic [7:0] prn;
    logic [aodm_pkg::LANES-1:0][7:0] lane;
    logic flag;
    logic dco;
    logic rst_out;
    logic [aodm_pkg::EV_BITS-1:0] status;
    logic [aodm_pkg::EV_BITS-1:0] mask;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } aodm_state_t;

  aodm_state_t st;
  aodm_state_t next_st;

  // mode decode; quad select ignored in base mode
  function automatic aodm_pkg::aodm_mode_t decode_mode(input logic dbl,
                                                       input logic quad);
    if (!dbl) begin
      decode_mode = aodm_pkg::MODE_BASE;
    end else if (!quad) begin
      decode_mode = aodm_pkg::MODE_DOUBLE;
    end else begin
      decode_mode = aodm_pkg::MODE_QUAD;
    end
  endfunction

  // data clock level: high in the first half of each period
  function automatic logic dco_level(input logic [3:0] cnt,
                                     input aodm_pkg::aodm_mode_t mode);
    unique case (mode)
      aodm_pkg::MODE_BASE: dco_level = ~cnt[1];
      aodm_pkg::MODE_DOUBLE: dco_level = ~cnt[2];
      aodm_pkg::MODE_QUAD: dco_level = ~cnt[3];
      default: dco_level = ~cnt[1];
    endcase
  endfunction

  // one step of the pattern register, taps 8,6,5,4
  function automatic logic [7:0] prn_step(input logic [7:0] v);
    prn_step = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // read data for a register offset; unmapped reads as zero
  function automatic logic [31:0] read_word(input logic [3:0] adr,
                                            input aodm_state_t s);
    read_word = 32'h0;
    unique case (adr)
      aodm_pkg::REG_STATUS: read_word[2:0] = s.status;
      aodm_pkg::REG_MASK: read_word[2:0] = s.mask;
      aodm_pkg::REG_INFO: read_word = {16'h0, s.prn,
                                       2'h0, s.phase,
                                       s.pin_s2[aodm_pkg::PIN_PRN],
                                       s.pin_s2[aodm_pkg::PIN_DRST],
                                       s.pin_s2[aodm_pkg::PIN_QUAD],
                                       s.pin_s2[aodm_pkg::PIN_DBL]};
      default: read_word = 32'h0;
    endcase
  endfunction

  logic sclk_rise;
  logic sclk_fall;
  logic drst_now;
  logic drst_release;
  logic [8:0] conv_word;
  logic [8:0] taken_word;
  logic lane_update;
  logic [aodm_pkg::EV_BITS-1:0] events;
  logic wb_take;
  logic status_read;
  aodm_pkg::aodm_mode_t mode;

  // edge finding on the synchronised sample clock
  assign sclk_rise = st.pin_s2[aodm_pkg::PIN_SCLK] & ~st.sclk_prev;
  assign sclk_fall = ~st.pin_s2[aodm_pkg::PIN_SCLK] & st.sclk_prev;
  assign drst_now = st.pin_s2[aodm_pkg::PIN_DRST];
  // release seen at the first sample rise with reset low
  assign drst_release = sclk_rise & st.drst_prev & ~drst_now;
  assign mode = decode_mode(st.pin_s2[aodm_pkg::PIN_DBL],
                            st.pin_s2[aodm_pkg::PIN_QUAD]);
  // lanes only move at phase zero; held while demux reset is in
  assign lane_update = sclk_fall & (st.phase == 2'h0) & ~drst_now;

  // converter word: offset binary passes straight, overflow saturates
  always_comb begin
    if (st.ovr_s2[0]) begin
      conv_word = {1'b1, aodm_pkg::CODE_FULL};
    end else if (st.ovr_s2[1]) begin
      conv_word = {1'b1, aodm_pkg::CODE_ZERO};
    end else begin
      conv_word = {1'b0, st.code_s2};
    end
  end

  // pattern word carries no over-range flag
  assign taken_word = st.pin_s2[aodm_pkg::PIN_PRN] ?
                      {1'b0, st.prn} : conv_word;

  // wishbone handshake, one wait state then ack
  assign wb_take = wb_cyc_i & wb_stb_i & ~st.ack;
  assign status_read = wb_take & ~wb_we_i &
                       (wb_adr_i == aodm_pkg::REG_STATUS);

  // hardware events feeding the sticky status bits
  always_comb begin
    events = '0;
    events[aodm_pkg::EV_OVER_RANGE] = lane_update &
      (st.hist[aodm_pkg::LAT_A][8] | st.hist[aodm_pkg::LAT_B][8] |
       st.hist[aodm_pkg::LAT_C][8] | st.hist[aodm_pkg::LAT_D][8]);
    events[aodm_pkg::EV_RESET_OUT] = sclk_fall & ~st.rst_out &
      (|st.mark[aodm_pkg::LAT_A:aodm_pkg::LAT_D]);
    events[aodm_pkg::EV_PATTERN_WRAP] = sclk_rise &
      st.pin_s2[aodm_pkg::PIN_PRN] & (st.prn == aodm_pkg::PATTERN_LAST);
  end

  // whole next state
  always_comb begin
    next_st = st;

    // two-flop synchronisers for every converter side pin
    next_st.pin_s1 = {test_pattern_select_i, quad_rate_select_i,
                      double_rate_select_i, demux_reset_i,
                      sample_clock_i};
    next_st.pin_s2 = st.pin_s1;
    next_st.code_s1 = quant_code_i;
    next_st.code_s2 = st.code_s1;
    next_st.ovr_s1 = {over_neg_i, over_pos_i};
    next_st.ovr_s2 = st.ovr_s1;
    next_st.sclk_prev = st.pin_s2[aodm_pkg::PIN_SCLK];

    // rising sample edge: take the sample, advance counters
    if (sclk_rise) begin
      next_st.drst_prev = drst_now;
      next_st.hist = {st.hist[aodm_pkg::HIST_DEPTH-2:0],
                      taken_word};
      next_st.mark = {st.mark[aodm_pkg::HIST_DEPTH-2:0],
                      drst_release};
      if (st.pin_s2[aodm_pkg::PIN_PRN]) begin
        next_st.prn = prn_step(st.prn);
      end
      if (drst_now) begin
        next_st.phase = 2'h0;
      end else if (drst_release) begin
        next_st.phase = aodm_pkg::PHASE_AT_RELEASE;
      end else begin
        next_st.phase = st.phase + 2'h1;
      end
      // data clock counter never stops, only realigned at release
      if (drst_release) begin
        next_st.dco_cnt = aodm_pkg::DCO_AT_RELEASE;
      end else begin
        next_st.dco_cnt = st.dco_cnt + 4'h1;
      end
    end

    // falling sample edge: half-clock output timing
    if (sclk_fall) begin
      next_st.dco = dco_level(st.dco_cnt, mode);
      // reset out spans one lane period, starting with lane d
      next_st.rst_out =
        |st.mark[aodm_pkg::LAT_A:aodm_pkg::LAT_D];
    end

    // lanes change every four samples, with the data clock rise in base mode
    if (lane_update) begin
      next_st.lane[0] = st.hist[aodm_pkg::LAT_A][7:0];
      next_st.lane[1] = st.hist[aodm_pkg::LAT_B][7:0];
      next_st.lane[2] = st.hist[aodm_pkg::LAT_C][7:0];
      next_st.lane[3] = st.hist[aodm_pkg::LAT_D][7:0];
      next_st.flag = events[aodm_pkg::EV_OVER_RANGE];
    end

    // bus access; status read clears, but a new event wins
    next_st.ack = wb_take;
    if (wb_take) begin
      next_st.dat = read_word(wb_adr_i, st);
      if (wb_we_i && wb_sel_i[0] &&
          wb_adr_i == aodm_pkg::REG_MASK) begin
        next_st.mask = wb_dat_i[aodm_pkg::EV_BITS-1:0];
      end
    end
    if (status_read) begin
      next_st.status = events;
    end else begin
      next_st.status = st.status | events;
    end
    next_st.irq = |(next_st.status & next_st.mask);

    if (srst_i) begin
      next_st = '0;
      next_st.prn = aodm_pkg::PATTERN_SEED;
      next_st.mask = aodm_pkg::MASK_RESET;
    end
  end

  // single state register
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // outputs are struct flops
  assign lane_a_o = st.lane[0];
  assign lane_b_o = st.lane[1];
  assign lane_c_o = st.lane[2];
  assign lane_d_o = st.lane[3];
  assign over_range_flag_o = st.flag;
  assign data_clock_out_o = st.dco;
  assign demux_reset_out_o = st.rst_out;
  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign irq_o = st.irq;

endmodule

`default_nettype wire

/* hw/aodm_pkg.sv */
// shared constants and types for the converter output demultiplexer
package aodm_pkg;

  // wishbone register byte offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_INFO = 4'h8;

  // status and mask bit positions
  localparam int EV_OVER_RANGE = 0;
  localparam int EV_RESET_OUT = 1;
  localparam int EV_PATTERN_WRAP = 2;
  localparam int EV_BITS = 3;

  // reset values and last pattern state
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [7:0] PATTERN_SEED = 8'h01;
  localparam logic [7:0] PATTERN_LAST = 8'h80;

  // synchronised pin positions
  localparam int PIN_SCLK = 0;
  localparam int PIN_DRST = 1;
  localparam int PIN_DBL = 2;
  localparam int PIN_QUAD = 3;
  localparam int PIN_PRN = 4;
  localparam int PIN_BITS = 5;

  // pipeline latencies in whole sample clocks, plus one half
  localparam int LAT_A = 10;
  localparam int LAT_B = 9;
  localparam int LAT_C = 8;
  localparam int LAT_D = 7;
  localparam int HIST_DEPTH = 11;
  localparam int LANES = 4;

  // counter values loaded at the release edge of the demux reset
  localparam logic [1:0] PHASE_AT_RELEASE = 2'h1;
  localparam logic [3:0] DCO_AT_RELEASE = 4'h9;

  // codes forced on range overflow
  localparam logic [7:0] CODE_FULL = 8'hff;
  localparam logic [7:0] CODE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    MODE_BASE,
    MODE_DOUBLE,
    MODE_QUAD
  } aodm_mode_t;

endpackage

/* sim/aodm_demux_asserts.sv */
// port checks for the converter output demultiplexer
`timescale 1ns/1ps
`default_nettype none
module aodm_demux_asserts (
  input wire logic clk_i, // clock
  input wire logic srst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // ack
  input wire logic irq_o, // interrupt
  input wire logic demux_reset_i, // demux reset in
  input wire logic demux_reset_out_o, // reset out
  input wire logic data_clock_out_o, // data clock
  input wire logic over_range_flag_o, // range flag
  input wire logic [7:0] lane_a_o, // lane a
  input wire logic [7:0] lane_b_o, // lane b
  input wire logic [7:0] lane_c_o, // lane c
  input wire logic [7:0] lane_d_o // lane d
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [7:0] rst_cnt;
  logic [8:0] dco_cnt;
  // run lengths; long pulses need counters, not repetition
  always_ff @(posedge clk_i) begin
    rst_cnt <= demux_reset_out_o ? rst_cnt + 8'h01 : 8'h00;
    dco_cnt <= data_clock_out_o ? dco_cnt + 9'h001 : 9'h000;
  end
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_next_edge_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  irq_fall_bus_a: assert property ($fell(irq_o) |-> $past(wb_cyc_i) ||
    $past(wb_cyc_i, 2) || $past(wb_cyc_i, 3) || $past(srst_i))
    else $error("interrupt dropped without bus access");
  rst_out_width_a: assert property ($fell(demux_reset_out_o) |->
    rst_cnt >= 8'h3e && rst_cnt <= 8'h42) else $error("reset out width");
  rst_out_dco_a: assert property ($rose(demux_reset_out_o) |->
    $rose(data_clock_out_o)) else $error("reset out off data clock");
  rst_out_late_a: assert property ($rose(demux_reset_out_o) |->
    !demux_reset_i && !$past(demux_reset_i, 100)) else $error("reset out early");
  dco_toggles_a: assert property (dco_cnt <= 9'h082)
    else $error("data clock stuck high");
  flag_code_a: assert property (over_range_flag_o |->
    lane_a_o inside {8'h00, 8'hff} || lane_b_o inside {8'h00, 8'hff} ||
    lane_c_o inside {8'h00, 8'hff} || lane_d_o inside {8'h00, 8'hff})
    else $error("range flag without saturated lane");
  cover property ($rose(demux_reset_out_o));
  cover property ($fell(irq_o));
  cover property (over_range_flag_o);
endmodule
bind aodm_demux aodm_demux_asserts chk (.clk_i, .srst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .irq_o, .demux_reset_i, .demux_reset_out_o,
  .data_clock_out_o, .over_range_flag_o, .lane_a_o, .lane_b_o, .lane_c_o,
  .lane_d_o);
`default_nettype wire

/* sim/aodm_capture.sv */
// capture side model: latches the lanes at each data clock rise
`timescale 1ns/1ps
`default_nettype none
module aodm_capture (
  input wire logic clk_i, // system clock
  input wire logic dco_i, // forwarded data clock
  input wire logic [31:0] lanes_i, // lanes a..d, a high
  input wire logic flag_i, // range flag
  output logic [31:0] word_o, // captured lanes
  output logic flag_o, // captured flag
  output logic got_o, // one-cycle capture pulse
  output logic [9:0] period_o // clocks between rises
);
  logic dco_q;
  logic [9:0] cnt;
  // data clock is the only capture reference, so no other timing assumed
  always_ff @(posedge clk_i) begin
    dco_q <= dco_i;
    got_o <= dco_i && !dco_q;
    cnt <= (dco_i && !dco_q) ? 10'h001 : cnt + 10'h001;
    if (dco_i && !dco_q) begin
      word_o <= lanes_i;
      flag_o <= flag_i;
      period_o <= cnt;
    end
  end
endmodule
`default_nettype wire

/* sim/adc_output_demux_prn_tb.sv */
// self-checking bench for the converter output demultiplexer
`timescale 1ns/1ps
`default_nettype none
module adc_output_demux_prn_tb;
  logic clk_i = 1'b0, srst_i = 1'b1, sample_clock_i = 1'b0;
  logic over_pos_i = 1'b0, over_neg_i = 1'b0, demux_reset_i = 1'b0;
  logic double_rate_select_i = 1'b0, quad_rate_select_i = 1'b0;
  logic test_pattern_select_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, over_range_flag_o, data_clock_out_o;
  logic demux_reset_out_o, wb_ack_o, irq_o, cflag, got;
  logic [7:0] quant_code_i = 8'h00, lane_a_o, lane_b_o, lane_c_o, lane_d_o, a;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, word, rd;
  logic [9:0] per;
  int fail_count = 0, checks = 0, n;
  logic [2:0] sdiv = 3'h0;
  logic [7:0] p;
  // system clock
  always #2.5 clk_i = ~clk_i;
  // 80 ns sample clock from clk; code steps at its fall, stable at rise
  always @(posedge clk_i) begin
    sdiv <= sdiv + 3'h1;
    if (sdiv == 3'h7) sample_clock_i <= ~sample_clock_i;
    if (sdiv == 3'h7 && sample_clock_i) quant_code_i <= quant_code_i + 8'h01;
  end
  aodm_demux dut (.clk_i, .srst_i, .sample_clock_i, .quant_code_i, .over_pos_i,
    .over_neg_i, .demux_reset_i, .double_rate_select_i, .quad_rate_select_i,
    .test_pattern_select_i, .lane_a_o, .lane_b_o, .lane_c_o, .lane_d_o,
    .over_range_flag_o, .data_clock_out_o, .demux_reset_out_o, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .irq_o);
  aodm_capture cap (.clk_i, .dco_i(data_clock_out_o), .lanes_i({lane_a_o,
    lane_b_o, lane_c_o, lane_d_o}), .flag_i(over_range_flag_o),
    .word_o(word), .flag_o(cflag), .got_o(got), .period_o(per));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) fail_count++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic next_word;
    int k;
    k = 0;
    do begin @(posedge clk_i); k++; end while (got !== 1'b1 && k < 600);
    if (got !== 1'b1) fail_count++;
  endtask
  task automatic chk_order;
    a = word[31:24];
    check(word, {a, a + 8'h01, a + 8'h02, a + 8'h03});
  endtask
  function automatic logic [7:0] st(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog, well beyond the expected run
  initial begin
    #400000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, aodm_pkg::REG_MASK, 32'h0, rd);
    check(rd, 32'h0);
    wb(1'b0, aodm_pkg::REG_INFO, 32'h0, rd);
    check(rd & 32'hffffffcf, 32'h100);
    wb(1'b0, 4'hc, 32'h0, rd);
    check(rd, 32'h0);
    wb(1'b1, aodm_pkg::REG_MASK, 32'hffffffff, rd);
    wb(1'b0, aodm_pkg::REG_MASK, 32'h0, rd);
    check(rd, 32'h7);
    wb(1'b1, aodm_pkg::REG_MASK, 32'h0, rd);
    // every rate code: data clock period, lane order, decode
    for (int i = 0; i < 4; i++) begin
      {double_rate_select_i, quad_rate_select_i} <= 2'(i);
      repeat (3) next_word;
      check(32'(per), (i < 2) ? 32'h40 : 32'h40 << (i - 1));
      chk_order;
      wb(1'b0, aodm_pkg::REG_INFO, 32'h0, rd);
      check(rd & 32'h3, {30'h0, i[0], i[1]});
    end
    {double_rate_select_i, quad_rate_select_i} <= 2'h0;
    // saturation, flag alignment, masked then unmasked interrupt
    over_pos_i <= 1'b1;
    repeat (3) next_word;
    check(word, 32'hffffffff);
    check(32'(cflag), 32'h1);
    check(32'(irq_o), 32'h0);
    wb(1'b1, aodm_pkg::REG_MASK, 32'h1, rd);
    repeat (2) @(posedge clk_i);
    check(32'(irq_o), 32'h1);
    over_pos_i <= 1'b0;
    over_neg_i <= 1'b1;
    repeat (3) next_word;
    check(word, 32'h0);
    check(32'(cflag), 32'h1);
    over_neg_i <= 1'b0;
    repeat (3) next_word;
    check(32'(cflag), 32'h0);
    wb(1'b0, aodm_pkg::REG_STATUS, 32'h0, rd);
    check(rd & 32'h1, 32'h1);
    wb(1'b0, aodm_pkg::REG_STATUS, 32'h0, rd);
    check(rd & 32'h1, 32'h0);
    repeat (2) @(posedge clk_i);
    check(32'(irq_o), 32'h0);
    // step model against the listed sequence, then a 255-state cycle
    check({24'h0, st(8'h04)}, 32'h08);
    check({24'h0, st(st(st(st(8'h08))))}, 32'h8e);
    p = 8'h01;
    n = 0;
    do begin p = st(p); n++; end while (p != 8'h01 && n < 300);
    check(n, 255);
    // pattern replaces converter data and wraps within 255 steps
    test_pattern_select_i <= 1'b1;
    repeat (3) next_word;
    a = word[31:24];
    check(word, {a, st(a), st(st(a)), st(st(st(a)))});
    repeat (4200) @(posedge clk_i);
    wb(1'b0, aodm_pkg::REG_STATUS, 32'h0, rd);
    check(rd & 32'h4, 32'h4);
    test_pattern_select_i <= 1'b0;
    // demux reset freezes lanes, then aligned reset out
    wb(1'b1, aodm_pkg::REG_MASK, 32'h2, rd);
    demux_reset_i <= 1'b1;
    repeat (100) @(posedge clk_i);
    a = lane_d_o;
    repeat (200) @(posedge clk_i);
    check({24'h0, lane_d_o}, {24'h0, a});
    wb(1'b0, aodm_pkg::REG_INFO, 32'h0, rd);
    check(rd & 32'h34, 32'h4);
    demux_reset_i <= 1'b0;
    n = 0;
    do begin @(posedge clk_i); n++; end
    while (demux_reset_out_o !== 1'b1 && n < 300);
    check(32'(n >= 118 && n <= 145), 32'h1);
    repeat (3) @(posedge clk_i);
    check(32'(irq_o), 32'h1);
    repeat (3) next_word;
    chk_order;
    report_and_stop;
  end
endmodule
`default_nettype wire
